// ---- rtl/rx_status_pkg.sv ----
// constants for the latched receive-status event bank
package rx_status_pkg;

  // register offsets on the host port
  localparam logic [7:0] RX_LATCHED_STATUS_3_OFS = 8'h92;
  localparam logic [7:0] RX_LATCHED_STATUS_4_OFS = 8'h93;
  localparam logic [7:0] RX_HDLC_LATCHED_STATUS_OFS = 8'h94;
  localparam logic [7:0] RX_LATCHED_STATUS_7_OFS = 8'h96;
  localparam logic [7:0] RX_SIGNALING_CHANGE_1_OFS = 8'h98;
  localparam logic [7:0] RX_SIGNALING_CHANGE_2_OFS = 8'h99;
  localparam logic [7:0] RX_SIGNALING_CHANGE_3_OFS = 8'h9A;
  localparam logic [7:0] RX_SIGNALING_CHANGE_4_OFS = 8'h9B;

  // reset value of every latched register
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // rx_latched_status_3 fields (t1 / e1 shared positions)
  localparam int CLK_LOST_FALL_B = 7;
  localparam int SPARE_GONE_B    = 6;
  localparam int LDN_GONE_B      = 5;
  localparam int V52_GONE_B      = 5;
  localparam int LUP_GONE_B      = 4;
  localparam int DMA_GONE_B      = 4;
  localparam int CLK_LOST_RISE_B = 3;
  localparam int SPARE_SEEN_B    = 2;
  localparam int LDN_SEEN_B      = 1;
  localparam int V52_SEEN_B      = 1;
  localparam int LUP_SEEN_B      = 0;
  localparam int DMA_SEEN_B      = 0;

  // rx_latched_status_4 fields
  localparam int ES_FULL_B  = 7;
  localparam int ES_EMPTY_B = 6;
  localparam int ES_SLIP_B  = 5;
  localparam int SIG_COS_B  = 3;
  localparam int ONE_SEC_B  = 2;
  localparam int TIMER_B    = 1;
  localparam int MF_B       = 0;

  // rx_hdlc_latched_status fields
  localparam int HD_OVR_B   = 5;
  localparam int HD_FIRST_B = 4;
  localparam int HD_END_B   = 3;
  localparam int HD_START_B = 2;
  localparam int HD_HWM_B   = 1;
  localparam int HD_NE_B    = 0;

  // rx_latched_status_7 fields
  localparam int RAI_CI_B = 5;
  localparam int AIS_CI_B = 4;
  localparam int SLC96_B  = 3;
  localparam int FDL_B    = 2;
  localparam int BOC_GONE_B = 1;
  localparam int BOC_SEEN_B = 0;
  localparam int SA6_B    = 1;
  localparam int SAX_B    = 0;

  // timing: system clock and line rates
  localparam int CLK_PERIOD_NS   = 100;
  localparam int RCLK_T1_KHZ     = 1544;
  localparam int RCLK_E1_KHZ     = 2048;
  localparam int CHAN_T1_NS      = 5181;
  localparam int CHAN_E1_NS      = 3906;
  localparam int CHAN_T1_CYC     = (CHAN_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAN_E1_CYC     = (CHAN_E1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ONE_SEC_US      = 1000000;
  localparam int TIMER_T1_US     = 42000;
  localparam int TIMER_E1_US     = 62500;
  localparam int MF_E1_US        = 2000;
  localparam int MF_E1_EDGES     = RCLK_E1_KHZ * MF_E1_US / 1000;

endpackage

// ---- rtl/rx_latched_status_bank.sv ----
// latched receive-status event bank with read-to-clear host port
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - T1 bit6 latches when spare match ends
// - T1 bit5 latches when loop-down ends
// - T1 bit4 latches when loop-up ends
// - clock loss sets bit3, recovery sets bit7
// - T1 bit2 latches on spare code start
// - T1 bit0 latches on loop-up start
// - E1 V5.2 link rise bit1, fall bit5
// - E1 two-multiframe distant alarm rise bit0
// - E1 distant alarm fall latches bit4
// - elastic store full sets bit7
// - elastic store empty sets bit6
// - any elastic store slip sets bit5
// - enabled channel signaling change sets bit3
// - one-second tick from receive clock
// - counter update tick per configured interval
// - multiframe tick on boundaries or 2ms
// - HDLC overrun abort sets bit5
// - HDLC first byte next sets bit4
// - packet end bit3, start bit2, read-clear
// - watermark rise bit1, not-empty rise bit0
// - RAI-CI in ESF alarm, AIS-CI in AIS
// - BOC seen bit0, BOC gone bit1
// - per-channel change bits hold until read
module rx_latched_status_bank
  import rx_status_pkg::*;
#(
  parameter int unsigned ONE_SEC_T1_EDGES = RCLK_T1_KHZ * (ONE_SEC_US / 1000),
  parameter int unsigned ONE_SEC_E1_EDGES = RCLK_E1_KHZ * (ONE_SEC_US / 1000),
  parameter int unsigned TIMER_T1_EDGES   = RCLK_T1_KHZ * TIMER_T1_US / 1000,
  parameter int unsigned TIMER_E1_EDGES   = RCLK_E1_KHZ * TIMER_E1_US / 1000
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // host register port
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_addr,
  output logic [7:0]       host_rd_data,
  output logic             host_rd_valid,
  // mode straps from the channel configuration
  input  wire logic        t1_mode,
  input  wire logic        esf_mode,
  input  wire logic        cas_enable,
  input  wire logic        error_counter_config_one_sec,
  input  wire logic        manual_latch,
  // recovered receive clock pin
  input  wire logic        rclk_pin,
  // code detector levels
  input  wire logic        spare_code_match,
  input  wire logic        loop_up_match,
  input  wire logic        loop_down_match,
  input  wire logic        v52_link_match,
  input  wire logic        boc_valid,
  // timeslot 16 frame 0 sample, once per multiframe
  input  wire logic        ts16_mf_strobe,
  input  wire logic        ts16_f0_bit6,
  // elastic store and framing events
  input  wire logic        estore_full_evt,
  input  wire logic        estore_empty_evt,
  input  wire logic        mf_boundary,
  // signaling change pulses and enables
  input  wire logic [31:0] sig_chan_change,
  input  wire logic [31:0] sig_change_enable,
  // hdlc receive events
  input  wire logic        hdlc_fifo_overrun,
  input  wire logic        hdlc_first_byte_next,
  input  wire logic        hdlc_packet_end,
  input  wire logic        hdlc_packet_start,
  input  wire logic        hdlc_above_watermark,
  input  wire logic        hdlc_fifo_not_empty,
  // alarm indications and codeword events
  input  wire logic        rai_active,
  input  wire logic        ais_active,
  input  wire logic        rai_ci_pattern,
  input  wire logic        ais_ci_pattern,
  input  wire logic        slc96_align,
  input  wire logic        fdl_full,
  input  wire logic        sa6_codeword,
  input  wire logic        sax_change,
  // live conditions
  output logic             rx_clock_lost,
  output logic             distant_mf_alarm
);

  // set wins over read-clear
  function automatic logic [7:0] latch8(input logic [7:0] q, input logic [7:0] set, input logic [7:0] clr);
    latch8 = (q & ~clr) | set;
  endfunction

  // registers and flags
  logic [7:0]  rx_latched_status_3_q;
  logic [7:0]  rx_latched_status_4_q;
  logic [7:0]  rx_hdlc_latched_status_q;
  logic [7:0]  rx_latched_status_7_q;
  logic [31:0] rss_q;
  logic [7:0]  rx_latched_status_3_set;
  logic [7:0]  rx_latched_status_4_set;
  logic [7:0]  rx_hdlc_latched_status_set;
  logic [7:0]  rx_latched_status_7_set;
  logic [7:0]  rd_value;
  logic        rclk_meta_q;
  logic        rclk_sync_q;
  logic        rclk_prev_q;
  logic        rclk_edge;
  logic [7:0]  lost_cnt_q;
  logic [7:0]  lost_limit;
  logic        lost_q;
  logic        lost_prev_q;
  logic        spare_prev_q;
  logic        lup_prev_q;
  logic        ldn_prev_q;
  logic        v52_prev_q;
  logic        boc_prev_q;
  logic        hwm_prev_q;
  logic        ne_prev_q;
  logic        dma_last_q;
  logic        dma_q;
  logic        dma_prev_q;
  logic [20:0] sec_cnt_q;
  logic [20:0] sec_limit;
  logic        sec_tick;
  logic [16:0] tmr_cnt_q;
  logic [16:0] tmr_limit;
  logic        tmr_tick;
  logic [12:0] mf_cnt_q;
  logic        mf_tick;

  // rising edge of the recovered clock after two sync stages
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rclk_meta_q <= 1'b0;
      rclk_sync_q <= 1'b0;
      rclk_prev_q <= 1'b0;
    end
    else
    begin
      rclk_meta_q <= rclk_pin;
      rclk_sync_q <= rclk_meta_q;
      rclk_prev_q <= rclk_sync_q;
    end
  end

  assign rclk_edge = rclk_sync_q & ~rclk_prev_q;

  // one channel time without a transition means clock lost
  assign lost_limit = t1_mode ? 8'(CHAN_T1_CYC) : 8'(CHAN_E1_CYC);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lost_cnt_q <= 8'h00;
      lost_q     <= 1'b0;
    end
    else if (rclk_sync_q != rclk_prev_q)
    begin
      lost_cnt_q <= 8'h00;
      lost_q     <= 1'b0;
    end
    else if (lost_cnt_q >= lost_limit)
    begin
      lost_q <= 1'b1;
    end
    else
    begin
      lost_cnt_q <= lost_cnt_q + 8'h01;
    end
  end

  assign rx_clock_lost = lost_q;

  // previous values of every edge-detected condition except the recovered clock, whose previous value is kept in the sync stages
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lost_prev_q  <= 1'b0;
      spare_prev_q <= 1'b0;
      lup_prev_q   <= 1'b0;
      ldn_prev_q   <= 1'b0;
      v52_prev_q   <= 1'b0;
      boc_prev_q   <= 1'b0;
      hwm_prev_q   <= 1'b0;
      ne_prev_q    <= 1'b0;
      dma_prev_q   <= 1'b0;
    end
    else
    begin
      lost_prev_q  <= lost_q;
      spare_prev_q <= spare_code_match;
      lup_prev_q   <= loop_up_match;
      ldn_prev_q   <= loop_down_match;
      v52_prev_q   <= v52_link_match;
      boc_prev_q   <= boc_valid;
      hwm_prev_q   <= hdlc_above_watermark;
      ne_prev_q    <= hdlc_fifo_not_empty;
      dma_prev_q   <= dma_q;
    end
  end

  // distant multiframe alarm: bit 6 set in two consecutive multiframes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dma_last_q <= 1'b0;
      dma_q      <= 1'b0;
    end
    else if (ts16_mf_strobe)
    begin
      dma_last_q <= ts16_f0_bit6;
      dma_q      <= ts16_f0_bit6 & (dma_last_q | dma_q);
    end
  end

  assign distant_mf_alarm = dma_q;

  // one-second interval counted in receive clock edges
  assign sec_limit = t1_mode ? 21'(ONE_SEC_T1_EDGES - 1) : 21'(ONE_SEC_E1_EDGES - 1);
  assign sec_tick  = rclk_edge & (sec_cnt_q >= sec_limit);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sec_cnt_q <= 21'h000000;
    else if (sec_tick)
      sec_cnt_q <= 21'h000000;
    else if (rclk_edge)
      sec_cnt_q <= sec_cnt_q + 21'h000001;
  end

  // short counter-update interval, 42ms t1 or 62.5ms e1
  assign tmr_limit = t1_mode ? 17'(TIMER_T1_EDGES - 1) : 17'(TIMER_E1_EDGES - 1);
  assign tmr_tick  = error_counter_config_one_sec ? sec_tick : (rclk_edge & (tmr_cnt_q >= tmr_limit));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tmr_cnt_q <= 17'h00000;
    else if (rclk_edge & (tmr_cnt_q >= tmr_limit))
      tmr_cnt_q <= 17'h00000;
    else if (rclk_edge)
      tmr_cnt_q <= tmr_cnt_q + 17'h00001;
  end

  // arbitrary 2ms boundary for e1 without cas
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mf_cnt_q <= 13'h0000;
    else if (rclk_edge & (mf_cnt_q >= 13'(MF_E1_EDGES - 1)))
      mf_cnt_q <= 13'h0000;
    else if (rclk_edge)
      mf_cnt_q <= mf_cnt_q + 13'h0001;
  end

  assign mf_tick = (t1_mode | cas_enable) ? mf_boundary
                 : (rclk_edge & (mf_cnt_q >= 13'(MF_E1_EDGES - 1)));

  // event vector for rx_latched_status_3, per mode
  always_comb
  begin
    rx_latched_status_3_set = 8'h00;
    rx_latched_status_3_set[CLK_LOST_FALL_B] = lost_prev_q & ~lost_q;
    rx_latched_status_3_set[CLK_LOST_RISE_B] = lost_q & ~lost_prev_q;
    if (t1_mode)
    begin
      rx_latched_status_3_set[SPARE_GONE_B] = spare_prev_q & ~spare_code_match;
      rx_latched_status_3_set[LDN_GONE_B]   = ldn_prev_q & ~loop_down_match;
      rx_latched_status_3_set[LUP_GONE_B]   = lup_prev_q & ~loop_up_match;
      rx_latched_status_3_set[SPARE_SEEN_B] = spare_code_match & ~spare_prev_q;
      rx_latched_status_3_set[LDN_SEEN_B]   = loop_down_match & ~ldn_prev_q;
      rx_latched_status_3_set[LUP_SEEN_B]   = loop_up_match & ~lup_prev_q;
    end
    else
    begin
      rx_latched_status_3_set[V52_GONE_B] = v52_prev_q & ~v52_link_match;
      rx_latched_status_3_set[V52_SEEN_B] = v52_link_match & ~v52_prev_q;
      rx_latched_status_3_set[DMA_GONE_B] = dma_prev_q & ~dma_q;
      rx_latched_status_3_set[DMA_SEEN_B] = dma_q & ~dma_prev_q;
    end
  end

  // event vector for rx_latched_status_4
  always_comb
  begin
    rx_latched_status_4_set = 8'h00;
    rx_latched_status_4_set[ES_FULL_B]  = estore_full_evt;
    rx_latched_status_4_set[ES_EMPTY_B] = estore_empty_evt;
    rx_latched_status_4_set[ES_SLIP_B]  = estore_full_evt | estore_empty_evt;
    rx_latched_status_4_set[SIG_COS_B]  = |(sig_chan_change & sig_change_enable);
    rx_latched_status_4_set[ONE_SEC_B]  = sec_tick;
    rx_latched_status_4_set[TIMER_B]    = tmr_tick | manual_latch;
    rx_latched_status_4_set[MF_B]       = mf_tick;
  end

  // event vector for the hdlc status register
  always_comb
  begin
    rx_hdlc_latched_status_set = 8'h00;
    rx_hdlc_latched_status_set[HD_OVR_B]   = hdlc_fifo_overrun;
    rx_hdlc_latched_status_set[HD_FIRST_B] = hdlc_first_byte_next;
    rx_hdlc_latched_status_set[HD_END_B]   = hdlc_packet_end;
    rx_hdlc_latched_status_set[HD_START_B] = hdlc_packet_start;
    rx_hdlc_latched_status_set[HD_HWM_B]   = hdlc_above_watermark & ~hwm_prev_q;
    rx_hdlc_latched_status_set[HD_NE_B]    = hdlc_fifo_not_empty & ~ne_prev_q;
  end

  // event vector for rx_latched_status_7, per mode
  always_comb
  begin
    rx_latched_status_7_set = 8'h00;
    if (t1_mode)
    begin
      rx_latched_status_7_set[RAI_CI_B]   = rai_ci_pattern & esf_mode & rai_active;
      rx_latched_status_7_set[AIS_CI_B]   = ais_ci_pattern & ais_active;
      rx_latched_status_7_set[SLC96_B]    = slc96_align;
      rx_latched_status_7_set[FDL_B]      = fdl_full;
      rx_latched_status_7_set[BOC_GONE_B] = boc_prev_q & ~boc_valid;
      rx_latched_status_7_set[BOC_SEEN_B] = boc_valid & ~boc_prev_q;
    end
    else
    begin
      rx_latched_status_7_set[SA6_B] = sa6_codeword;
      rx_latched_status_7_set[SAX_B] = sax_change;
    end
  end

  // read mux, unmapped addresses answer zero
  always_comb
  begin
    case (host_addr)
      RX_LATCHED_STATUS_3_OFS: rd_value = rx_latched_status_3_q;
      RX_LATCHED_STATUS_4_OFS: rd_value = rx_latched_status_4_q;
      RX_HDLC_LATCHED_STATUS_OFS: rd_value = rx_hdlc_latched_status_q;
      RX_LATCHED_STATUS_7_OFS: rd_value = rx_latched_status_7_q;
      RX_SIGNALING_CHANGE_1_OFS: rd_value = rss_q[7:0];
      RX_SIGNALING_CHANGE_2_OFS: rd_value = rss_q[15:8];
      RX_SIGNALING_CHANGE_3_OFS: rd_value = rss_q[23:16];
      RX_SIGNALING_CHANGE_4_OFS: rd_value = rss_q[31:24];
      default:  rd_value = 8'h00;
    endcase
  end

  // read data and valid, one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      host_rd_data  <= 8'h00;
      host_rd_valid <= 1'b0;
    end
    else
    begin
      host_rd_valid <= host_rd;
      if (host_rd)
        host_rd_data <= rd_value;
    end
  end

  // latched status: clear only the bits returned, new events win
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_latched_status_3_q <= STATUS_RESET;
      rx_latched_status_4_q <= STATUS_RESET;
      rx_hdlc_latched_status_q <= STATUS_RESET;
      rx_latched_status_7_q <= STATUS_RESET;
    end
    else
    begin
      rx_latched_status_3_q <= latch8(rx_latched_status_3_q, rx_latched_status_3_set, (host_rd && host_addr == RX_LATCHED_STATUS_3_OFS) ? rx_latched_status_3_q : 8'h00);
      rx_latched_status_4_q <= latch8(rx_latched_status_4_q, rx_latched_status_4_set, (host_rd && host_addr == RX_LATCHED_STATUS_4_OFS) ? rx_latched_status_4_q : 8'h00);
      rx_hdlc_latched_status_q <= latch8(rx_hdlc_latched_status_q, rx_hdlc_latched_status_set, (host_rd && host_addr == RX_HDLC_LATCHED_STATUS_OFS) ? rx_hdlc_latched_status_q : 8'h00);
      rx_latched_status_7_q <= latch8(rx_latched_status_7_q, rx_latched_status_7_set, (host_rd && host_addr == RX_LATCHED_STATUS_7_OFS) ? rx_latched_status_7_q : 8'h00);
    end
  end

  // per-channel signaling change bits, four bytes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rss_q <= {4{STATUS_RESET}};
    else
    begin
      rss_q[7:0]   <= latch8(rss_q[7:0], sig_chan_change[7:0],
                             (host_rd && host_addr == RX_SIGNALING_CHANGE_1_OFS) ? rss_q[7:0] : 8'h00);
      rss_q[15:8]  <= latch8(rss_q[15:8], sig_chan_change[15:8],
                             (host_rd && host_addr == RX_SIGNALING_CHANGE_2_OFS) ? rss_q[15:8] : 8'h00);
      rss_q[23:16] <= latch8(rss_q[23:16], sig_chan_change[23:16],
                             (host_rd && host_addr == RX_SIGNALING_CHANGE_3_OFS) ? rss_q[23:16] : 8'h00);
      rss_q[31:24] <= latch8(rss_q[31:24], sig_chan_change[31:24],
                             (host_rd && host_addr == RX_SIGNALING_CHANGE_4_OFS) ? rss_q[31:24] : 8'h00);
    end
  end

endmodule

`default_nettype wire

// ---- tb/rx_status_checker.sv ----
// concurrent checks on the latched receive-status bank ports
`timescale 1ns/10ps
`default_nettype none
module rx_status_checker
  import rx_status_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // host port
  input wire logic        host_rd,
  input wire logic [7:0]  host_addr,
  input wire logic [7:0]  host_rd_data,
  // modes and event sources
  input wire logic        t1_mode,
  input wire logic        esf_mode,
  input wire logic        rai_active,
  input wire logic        rai_ci_pattern,
  input wire logic        spare_code_match,
  input wire logic        loop_up_match,
  input wire logic        v52_link_match,
  input wire logic        ts16_mf_strobe,
  input wire logic        ts16_f0_bit6,
  input wire logic        estore_full_evt,
  input wire logic [31:0] sig_chan_change,
  input wire logic [31:0] sig_change_enable,
  input wire logic        hdlc_packet_end,
  input wire logic        hdlc_packet_start,
  // live conditions
  input wire logic        rx_clock_lost,
  input wire logic        distant_mf_alarm
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // edge then an idle cycle then a read: the bit must come back set
  chk_loop_up_seen: assert property (
    t1_mode && $rose(loop_up_match) ##1 !host_rd ##1 host_rd && host_addr == RX_LATCHED_STATUS_3_OFS
    |=> host_rd_data[LUP_SEEN_B]) else $error("loop-up start not latched");
  chk_spare_gone: assert property (
    t1_mode && $fell(spare_code_match) ##1 !host_rd ##1 host_rd && host_addr == RX_LATCHED_STATUS_3_OFS
    |=> host_rd_data[SPARE_GONE_B]) else $error("spare code end not latched");
  chk_v52_seen: assert property (
    !t1_mode && $rose(v52_link_match) ##1 !host_rd ##1 host_rd && host_addr == RX_LATCHED_STATUS_3_OFS
    |=> host_rd_data[V52_SEEN_B]) else $error("link start not latched");
  chk_clock_lost: assert property (
    $rose(rx_clock_lost) ##1 !host_rd ##1 host_rd && host_addr == RX_LATCHED_STATUS_3_OFS
    |=> host_rd_data[CLK_LOST_RISE_B]) else $error("clock loss not latched");
  chk_dma_set: assert property (
    !t1_mode && ts16_mf_strobe && ts16_f0_bit6 ##1 !ts16_mf_strobe ##1 ts16_mf_strobe && ts16_f0_bit6
    |-> ##[1:2] distant_mf_alarm) else $error("distant alarm not raised");
  chk_slip_full: assert property (
    estore_full_evt ##1 !host_rd ##1 host_rd && host_addr == RX_LATCHED_STATUS_4_OFS
    |=> host_rd_data[ES_FULL_B] && host_rd_data[ES_SLIP_B]) else $error("full slip not latched");
  chk_sig_cos: assert property (
    (|(sig_chan_change & sig_change_enable)) ##1 !host_rd ##1 host_rd && host_addr == RX_LATCHED_STATUS_4_OFS
    |=> host_rd_data[SIG_COS_B]) else $error("signaling change not latched");
  chk_hdlc_clear: assert property (
    host_rd && host_addr == RX_HDLC_LATCHED_STATUS_OFS && !hdlc_packet_start && !hdlc_packet_end ##1 host_rd && host_addr == RX_HDLC_LATCHED_STATUS_OFS
    |=> !host_rd_data[HD_END_B] && !host_rd_data[HD_START_B]) else $error("packet bits not cleared");
  chk_rai_gate: assert property (
    host_rd && host_addr == RX_LATCHED_STATUS_7_OFS && !(rai_ci_pattern && esf_mode && rai_active) ##1 host_rd && host_addr == RX_LATCHED_STATUS_7_OFS
    |=> !host_rd_data[RAI_CI_B]) else $error("remote alarm codeword wrongly latched");
endmodule
bind rx_latched_status_bank rx_status_checker rx_status_checker_inst (.clk, .sys_rst, .host_rd, .host_addr,
  .host_rd_data, .t1_mode, .esf_mode, .rai_active, .rai_ci_pattern, .spare_code_match, .loop_up_match,
  .v52_link_match, .ts16_mf_strobe, .ts16_f0_bit6, .estore_full_evt, .sig_chan_change, .sig_change_enable,
  .hdlc_packet_end, .hdlc_packet_start, .rx_clock_lost, .distant_mf_alarm);
`default_nettype wire

// ---- tb/host_cpu_model.sv ----
// host processor model that reads the latched registers
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
  // clock
  input  wire logic       clk,
  // host register port
  output logic            host_rd,
  output logic [7:0]      host_addr
);
  // expected read data, oldest first
  logic [7:0] exp_q [$];
  initial
  begin
    host_rd = 1'b0;
    host_addr = 8'h00;
  end
  // one read: strobe for one edge, address held with it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
  endtask
  // two reads of one offset on consecutive edges
  task automatic rd2(input logic [7:0] a, input logic [7:0] e1, input logic [7:0] e2);
    exp_q.push_back(e1);
    exp_q.push_back(e2);
    @(posedge clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    @(posedge clk);
    host_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the latched receive-status bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rx_status_pkg::*;
  logic        clk;
  logic        sys_rst;
  logic        rclk;
  logic [14:0] pv;
  logic [11:0] lv;
  logic [31:0] chg;
  logic [31:0] en;
  logic [31:0] rnd;
  logic        host_rd;
  logic [7:0]  host_addr;
  logic [7:0]  host_rd_data;
  logic        host_rd_valid;
  logic        rx_clock_lost;
  logic        cas;
  logic [7:0]  want;
  int          miscompares;
  int          comparisons;
  // pulses in pv, levels and modes in lv
  rx_latched_status_bank #(.ONE_SEC_T1_EDGES(20), .ONE_SEC_E1_EDGES(24), .TIMER_T1_EDGES(6), .TIMER_E1_EDGES(8))
  rx_latched_status_bank_inst (.clk, .sys_rst, .host_rd, .host_addr, .host_rd_data, .host_rd_valid,
    .t1_mode(lv[9]), .esf_mode(lv[10]), .cas_enable(cas), .error_counter_config_one_sec(1'b0), .manual_latch(pv[3]),
    .rclk_pin(rclk), .spare_code_match(lv[0]), .loop_up_match(lv[1]), .loop_down_match(lv[2]),
    .v52_link_match(lv[3]), .boc_valid(lv[4]), .ts16_mf_strobe(pv[4]), .ts16_f0_bit6(lv[11]),
    .estore_full_evt(pv[0]), .estore_empty_evt(pv[1]), .mf_boundary(pv[2]), .sig_chan_change(chg),
    .sig_change_enable(en), .hdlc_fifo_overrun(pv[5]), .hdlc_first_byte_next(pv[6]), .hdlc_packet_end(pv[7]),
    .hdlc_packet_start(pv[8]), .hdlc_above_watermark(lv[5]), .hdlc_fifo_not_empty(lv[6]), .rai_active(lv[7]),
    .ais_active(lv[8]), .rai_ci_pattern(pv[9]), .ais_ci_pattern(pv[10]), .slc96_align(pv[11]),
    .fdl_full(pv[12]), .sa6_codeword(pv[13]), .sax_change(pv[14]), .rx_clock_lost, .distant_mf_alarm());
  host_cpu_model host_cpu_model_inst (.clk, .host_rd, .host_addr);
  always #50 clk = ~clk;
  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic pulse(input logic [14:0] m);
    @(posedge clk);
    pv <= m;
    @(posedge clk);
    pv <= '0;
  endtask
  task automatic set_lv(input int b, input logic v);
    @(posedge clk);
    lv[b] <= v;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_cpu_model_inst.rd(a, e);
  endtask
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // compare each returned byte with the oldest note
  always @(posedge clk)
  begin
    if (host_rd_valid === 1'b1)
    begin
      want = host_cpu_model_inst.exp_q.pop_front();
      comparisons++;
      if (host_rd_data !== want)
      begin
        $display("MISMATCH %0t read %h expected %h", $time, host_rd_data, want);
        miscompares++;
      end
    end
  end
  // hang guard
  initial
  begin
    repeat (6000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    rclk = 1'b0;
    pv = '0;
    lv = 12'h200;
    chg = '0;
    en = '0;
    rnd = 32'h954A;
    cas = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, then an unmapped offset
    for (int k = 0; k < 4; k++)
      rd(RX_LATCHED_STATUS_3_OFS + 8'(k), STATUS_RESET);
    rd(RX_LATCHED_STATUS_7_OFS, STATUS_RESET);
    rd(8'h95, 8'h00);
    // receive clock still, then running, then still again
    repeat (60) @(posedge clk);
    repeat (48)
    begin
      repeat (4) @(posedge clk);
      rclk <= ~rclk;
    end
    @(posedge rx_clock_lost);
    @(posedge clk);
    rd(RX_LATCHED_STATUS_3_OFS, 8'h88);
    rd(RX_LATCHED_STATUS_4_OFS, 8'h06);
    // t1 code detectors, rise and fall of each
    set_lv(0, 1);
    set_lv(1, 1);
    set_lv(2, 1);
    set_lv(1, 0);
    set_lv(2, 0);
    set_lv(0, 0);
    rd(RX_LATCHED_STATUS_3_OFS, 8'h77);
    set_lv(1, 1);
    rd(RX_LATCHED_STATUS_3_OFS, 8'h01);
    // elastic store, multiframe and manual latch events
    pulse(15'h000E);
    pulse(15'h0001);
    rd(RX_LATCHED_STATUS_4_OFS, 8'hE3);
    // event in the cycle of a clearing read survives it
    fork
      host_cpu_model_inst.rd2(RX_LATCHED_STATUS_4_OFS, 8'h00, 8'h60);
      pulse(15'h0002);
    join
    // random enables and channel changes
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      @(posedge clk);
      en <= (i == 0) ? 32'h0 : rnd;
      rnd = lfsr(rnd);
      @(posedge clk);
      chg <= rnd;
      @(posedge clk);
      chg <= '0;
      rd(RX_LATCHED_STATUS_4_OFS, {4'h0, |(rnd & en), 3'h0});
      for (int k = 0; k < 4; k++)
        rd(RX_SIGNALING_CHANGE_1_OFS + 8'(k), rnd[8*k +: 8]);
    end
    // e1: loop-up edges ignored, link and distant alarm edges latched
    set_lv(9, 0);
    set_lv(1, 0);
    set_lv(1, 1);
    set_lv(1, 0);
    rd(RX_LATCHED_STATUS_3_OFS, 8'h00);
    set_lv(3, 1);
    set_lv(3, 0);
    set_lv(11, 1);
    pulse(15'h0010);
    pulse(15'h0010);
    set_lv(11, 0);
    pulse(15'h0010);
    set_lv(3, 1);
    rd(RX_LATCHED_STATUS_3_OFS, 8'h33);
    // e1 boundary input ignored without cas, used with it
    pulse(15'h0004);
    @(posedge clk);
    cas <= 1'b1;
    pulse(15'h0004);
    rd(RX_LATCHED_STATUS_4_OFS, 8'h01);
    // hdlc events, then two clearing reads in a row
    pulse(15'h01E0);
    set_lv(5, 1);
    set_lv(6, 1);
    rd(RX_HDLC_LATCHED_STATUS_OFS, 8'h3F);
    host_cpu_model_inst.rd2(RX_HDLC_LATCHED_STATUS_OFS, 8'h00, 8'h00);
    // codeword events in e1, then t1 alarm codewords and bit-oriented codes
    pulse(15'h6000);
    rd(RX_LATCHED_STATUS_7_OFS, 8'h03);
    set_lv(9, 1);
    set_lv(7, 1);
    pulse(15'h0200);
    host_cpu_model_inst.rd2(RX_LATCHED_STATUS_7_OFS, 8'h00, 8'h00);
    set_lv(10, 1);
    pulse(15'h0200);
    set_lv(8, 1);
    pulse(15'h1C00);
    set_lv(4, 1);
    set_lv(4, 0);
    rd(RX_LATCHED_STATUS_7_OFS, 8'h3F);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
